/* File: src/ram_attr_gate.v */
`timescale 1ns/10ps
`default_nettype none
`include "sysbus_map.vh"

module ram_attr_gate (
   // clock and reset
   input  wire        clock_in,
   input  wire        rst_in,
   // attribute loading
   input  wire        attr_wr_in,
   input  wire [6:0]  attr_idx_in,
   input  wire [1:0]  attr_val_in,
   // placement straps and protection
   input  wire [5:0]  win_sel_in,
   input  wire [7:0]  base_kb_in,
   input  wire [7:0]  wp_groups_in,
   // backplane cycle under test
   input  wire [23:1] bp_addr_in,
   input  wire        bp_we_in,
   output wire        hit_out,
   output wire        refuse_out,
   output wire        drop_write_out,
   output wire [16:1] ram_addr_out
);

   reg  [1:0] attr_reg [0:127];
   wire [7:0] off;
   wire [6:0] blk;
   wire [1:0] attr;
   integer    i;

   // one attribute per 1K block; reset to local so nothing leaks early
   always @(posedge clock_in) begin
      if (rst_in) begin
         for (i = 0; i < 128; i = i + 1)
            attr_reg[i] <= `ATTR_LOCAL;
      end else if (attr_wr_in) begin
         attr_reg[attr_idx_in] <= attr_val_in;
      end
   end

   assign off  = bp_addr_in[17:10] - base_kb_in;
   assign blk  = off[6:0];
   assign attr = attr_reg[blk];
   // base wraps within the window; 128 blocks fit in it
   assign hit_out = (bp_addr_in[23:18] == win_sel_in) && !off[7];
   assign refuse_out = (attr == `ATTR_LOCAL);
   // one protect bit per group of sixteen blocks
   assign drop_write_out = bp_we_in &&
      ((attr == `ATTR_SHARED_RO) ||
       ((attr == `ATTR_SHARED_WP) && wp_groups_in[blk[6:4]]));
   assign ram_addr_out = {blk, bp_addr_in[9:1]};

endmodule // ram_attr_gate
`default_nettype wire

/* File: src/sysbus_bridge.v */
`timescale 1ns/10ps
`default_nettype none
`include "sysbus_map.vh"

module sysbus_bridge (
   // clock and reset
   input  wire        clock_in,
   input  wire        rst_in,
   // straps
   input  wire [5:0]  win_sel_in,
   input  wire [7:0]  base_kb_in,
   input  wire [2:0]  bus_level_in,
   input  wire        ser_wired_in,
   input  wire [2:0]  ser_level_in,
   // attribute loading
   input  wire        attr_wr_in,
   input  wire [6:0]  attr_idx_in,
   input  wire [1:0]  attr_val_in,
   // processor port
   input  wire        cpu_req_in,
   input  wire        cpu_we_in,
   input  wire        cpu_iack_in,
   input  wire [23:1] cpu_addr_in,
   input  wire [15:0] cpu_wdata_in,
   output reg  [15:0] cpu_rdata_out,
   output reg         cpu_ack_out,
   output reg         cpu_err_out,
   // serial interrupts
   input  wire [1:0]  ser_irq_in,
   output reg  [2:0]  cpu_ipl_out,
   // ram port
   output reg         ram_en_out,
   output reg         ram_we_out,
   output reg  [16:1] ram_addr_out,
   output reg  [15:0] ram_wdata_out,
   input  wire [15:0] ram_rdata_in,
   // backplane slave
   input  wire        bp_sel_in,
   input  wire        bp_we_in,
   input  wire [23:1] bp_addr_in,
   input  wire [15:0] bp_wdata_in,
   output reg  [15:0] bp_rdata_out,
   output reg         bp_ack_out,
   output reg         bp_err_out,
   // backplane master
   output reg  [4:0]  bus_req_out,
   input  wire        bus_grant_in,
   output reg         bus_busy_out,
   output reg         mst_strobe_out,
   output reg         mst_we_out,
   output reg  [23:1] mst_addr_out,
   output reg  [15:0] mst_wdata_out,
   input  wire        mst_ack_in,
   input  wire [15:0] mst_rdata_in,
   // backplane interrupter
   output reg  [7:1]  bp_irq_out
);

   localparam C_IDLE = 3'h0;
   localparam C_RAM  = 3'h1;
   localparam C_RD   = 3'h2;
   localparam C_BREQ = 3'h3;
   localparam C_XFER = 3'h4;
   localparam C_END  = 3'h5;
   localparam B_IDLE = 2'h0;
   localparam B_RAM  = 2'h1;
   localparam B_RD   = 2'h2;
   localparam B_ACK  = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers, two flops for straps, serial interrupts, select, grant and master ack; backplane address, data and write go direct
   wire [25:0] sync_d;
   reg  [25:0] sync1_reg;
   reg  [25:0] sync2_reg;
   assign sync_d = {win_sel_in, base_kb_in, bus_level_in, ser_wired_in,
                    ser_level_in, ser_irq_in, bp_sel_in, bus_grant_in,
                    mst_ack_in};
   always @(posedge clock_in) begin
      if (rst_in) begin
         sync1_reg <= 26'h0000000;
         sync2_reg <= 26'h0000000;
      end else begin
         sync1_reg <= sync_d;
         sync2_reg <= sync1_reg;
      end
   end
   wire [5:0] win_s    = sync2_reg[25:20];
   wire [7:0] base_s   = sync2_reg[19:12];
   wire [2:0] blvl_s   = sync2_reg[11:9];
   wire       swire_s  = sync2_reg[8];
   wire [2:0] slvl_s   = sync2_reg[7:5];
   wire [1:0] sirq_s   = sync2_reg[4:3];
   wire       bpsel_s  = sync2_reg[2];
   wire       grant_s  = sync2_reg[1];
   wire       mack_s   = sync2_reg[0];

   ////////////////////////////////////////////////////////////////////////
   // state
   reg [2:0]  cst_reg;
   reg [1:0]  bst_reg;
   reg [15:0] ctrl_reg;
   reg [7:0]  vec_reg;
   reg        ind_req_reg;
   reg        master_reg;

   wire hit;
   wire refuse;
   wire drop_write;
   wire [16:1] bp_ram_addr;

   ram_attr_gate gate (
      .clock_in       (clock_in),
      .rst_in         (rst_in),
      .attr_wr_in     (attr_wr_in),
      .attr_idx_in    (attr_idx_in),
      .attr_val_in    (attr_val_in),
      .win_sel_in     (win_s),
      .base_kb_in     (base_s),
      .wp_groups_in   (ctrl_reg[`CTRL_WP_MSB:`CTRL_WP_LSB]),
      .bp_addr_in     (bp_addr_in),
      .bp_we_in       (bp_we_in),
      .hit_out        (hit),
      .refuse_out     (refuse),
      .drop_write_out (drop_write),
      .ram_addr_out   (bp_ram_addr)
   );

   ////////////////////////////////////////////////////////////////////////
   // processor decode and ram arbitration, processor first
   wire [23:0] cpu_byte = {cpu_addr_in, 1'b0};
   wire is_ram  = (cpu_addr_in[23:17] == `RAM_TOP_BITS);
   wire is_stat = (cpu_byte == `STAT_ADDR);
   wire is_bad  = (cpu_addr_in[23:19] == `ONBOARD_HI) ||
                  (cpu_addr_in[23:13] == `CHAN_HI);
   wire cpu_go  = (cst_reg == C_IDLE) && cpu_req_in && !cpu_iack_in &&
                  is_ram && (bst_reg != B_RAM);
   wire bp_go   = (bst_reg == B_IDLE) && bpsel_s && hit && !refuse &&
                  !drop_write && !cpu_go && (cst_reg != C_RAM);
   wire req_on  = ctrl_reg[`CTRL_DIRECT] || ind_req_reg;
   wire [2:0] blvl = (blvl_s > `BUS_LEVEL_MAX) ? `BUS_LEVEL_MAX : blvl_s;
   wire [2:0] irq_lvl = ctrl_reg[`CTRL_IRQ_MSB:`CTRL_IRQ_LSB];
   wire [2:0] slvl = (slvl_s == 3'h0 || slvl_s > `SER_LEVEL_MAX) ?
                     `SER_LEVEL_MAX : slvl_s;

   ////////////////////////////////////////////////////////////////////////
   // shared ram port
   always @(posedge clock_in) begin
      if (rst_in) begin
         ram_en_out    <= 1'b0;
         ram_we_out    <= 1'b0;
         ram_addr_out  <= 16'h0000;
         ram_wdata_out <= 16'h0000;
      end else if (cpu_go) begin
         ram_en_out    <= 1'b1;
         ram_we_out    <= cpu_we_in;
         ram_addr_out  <= cpu_addr_in[16:1];
         ram_wdata_out <= cpu_wdata_in;
      end else if (bp_go) begin
         ram_en_out    <= 1'b1;
         ram_we_out    <= bp_we_in;
         ram_addr_out  <= bp_ram_addr;
         ram_wdata_out <= bp_wdata_in;
      end else begin
         ram_en_out    <= 1'b0;
         ram_we_out    <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // processor side
   always @(posedge clock_in) begin
      if (rst_in) begin
         cst_reg        <= C_IDLE;
         ctrl_reg       <= `CTRL_RESET;
         vec_reg        <= `VEC_RESET;
         ind_req_reg    <= 1'b0;
         cpu_rdata_out  <= 16'h0000;
         cpu_ack_out    <= 1'b0;
         cpu_err_out    <= 1'b0;
         mst_strobe_out <= 1'b0;
         mst_we_out     <= 1'b0;
         mst_addr_out   <= 23'h000000;
         mst_wdata_out  <= 16'h0000;
      end else begin
         cpu_ack_out <= 1'b0;
         cpu_err_out <= 1'b0;
         case (cst_reg)
            C_IDLE: begin
               if (cpu_req_in && cpu_iack_in) begin
                  cpu_rdata_out <= {8'h00, vec_reg};
                  cpu_ack_out   <= 1'b1;
                  cst_reg       <= C_END;
               end else if (cpu_go) begin
                  // image writes land in ram too; reads give ram only
                  if (cpu_we_in && cpu_byte == `CTRL_IMG_ADDR)
                     ctrl_reg <= cpu_wdata_in;
                  if (cpu_we_in && cpu_byte == `VEC_IMG_ADDR)
                     vec_reg <= cpu_wdata_in[7:0];
                  cst_reg <= C_RAM;
               end else if (cpu_req_in && !is_ram && is_stat) begin
                  cpu_rdata_out <= {14'h0000, ind_req_reg, master_reg};
                  cpu_ack_out   <= 1'b1;
                  cst_reg       <= C_END;
               end else if (cpu_req_in && !is_ram && is_bad) begin
                  cpu_err_out <= 1'b1;
                  cst_reg     <= C_END;
               end else if (cpu_req_in && !is_ram) begin
                  // off-board only: local work never touches the backplane
                  mst_we_out    <= cpu_we_in;
                  mst_addr_out  <= cpu_addr_in;
                  mst_wdata_out <= cpu_wdata_in;
                  if (!master_reg)
                     ind_req_reg <= 1'b1;
                  cst_reg <= C_BREQ;
               end
            end
            C_RAM: cst_reg <= C_RD;
            C_RD: begin
               cpu_rdata_out <= ram_rdata_in;
               cpu_ack_out   <= 1'b1;
               cst_reg       <= C_END;
            end
            C_BREQ: begin
               if (master_reg) begin
                  mst_strobe_out <= 1'b1;
                  cst_reg        <= C_XFER;
               end
            end
            C_XFER: begin
               if (mack_s) begin
                  mst_strobe_out <= 1'b0;
                  cpu_rdata_out  <= mst_rdata_in;
                  cpu_ack_out    <= 1'b1;
                  ind_req_reg    <= 1'b0;
                  cst_reg        <= C_END;
               end
            end
            default: begin
               // wait for both handshakes to fall before the next access
               if (!cpu_req_in && !mack_s)
                  cst_reg <= C_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mastership, interrupter and serial merge
   always @(posedge clock_in) begin
      if (rst_in) begin
         master_reg   <= 1'b0;
         bus_busy_out <= 1'b0;
         bus_req_out  <= 5'h00;
         bp_irq_out   <= 7'h00;
         cpu_ipl_out  <= 3'h0;
      end else begin
         // dropping the request also drops mastership at once
         master_reg   <= req_on && (master_reg || grant_s);
         bus_busy_out <= req_on && (master_reg || grant_s);
         bus_req_out  <= req_on ? (5'h01 << blvl) : 5'h00;
         bp_irq_out   <= (irq_lvl == 3'h0) ? 7'h00 :
                         (7'h01 << (irq_lvl - 3'h1));
         if (|sirq_s)
            cpu_ipl_out <= swire_s ? slvl : `SER_LEVEL_DFLT;
         else
            cpu_ipl_out <= 3'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // backplane slave into shared ram
   always @(posedge clock_in) begin
      if (rst_in) begin
         bst_reg      <= B_IDLE;
         bp_rdata_out <= 16'h0000;
         bp_ack_out   <= 1'b0;
         bp_err_out   <= 1'b0;
      end else begin
         case (bst_reg)
            B_IDLE: begin
               if (bpsel_s && hit && refuse) begin
                  bp_err_out <= 1'b1;
                  bst_reg    <= B_ACK;
               end else if (bpsel_s && hit && drop_write) begin
                  // acknowledged, but the ram is never written
                  bp_ack_out <= 1'b1;
                  bst_reg    <= B_ACK;
               end else if (bp_go) begin
                  bst_reg <= B_RAM;
               end
            end
            B_RAM: bst_reg <= B_RD;
            B_RD: begin
               bp_rdata_out <= ram_rdata_in;
               bp_ack_out   <= 1'b1;
               bst_reg      <= B_ACK;
            end
            default: begin
               if (!bpsel_s) begin
                  bp_ack_out <= 1'b0;
                  bp_err_out <= 1'b0;
                  bst_reg    <= B_IDLE;
               end
            end
         endcase
      end
   end

endmodule // sysbus_bridge
`default_nettype wire

/* File: src/sysbus_map.vh */
// How it works
// - the shared RAM answers backplane cycles at a base set in 1K steps inside a strapped 256K window.
// - every 1K RAM block holds one of four attributes: local, shared read/write, shared read-only, shared protectable.
// - a backplane cycle that hits a local block is refused; only the on-board processor reaches it.
// - the processor turns on write protection for protectable blocks by setting control register bits.
// - mastership is requested on one of five levels, picked by a strap.
// - mastership won through the control register is held across accesses until the program clears it.
// - a processor access to the backplane while not master raises a request at the strapped level by itself.
// - after an indirectly requested access finishes the board releases mastership with no software help.
// - the local bus is connected to the backplane only for off-board accesses.
// - a processor write of a non-zero value into the interrupt bits raises a backplane interrupt request.
// - the interrupt request drives only the one of seven lines that matches the written level.
// - both serial interrupts merge onto one processor line at level six, or a wired level one to five.
// - in the serial interrupt acknowledge cycle the processor data lines carry a program-supplied vector.
// - the control register is only an image at the top of RAM and is never read back directly.
`ifndef SYSBUS_MAP_VH
`define SYSBUS_MAP_VH

// processor address map
`define RAM_TOP_BITS    7'h00
`define CTRL_IMG_ADDR   24'h01FFF0
`define VEC_IMG_ADDR    24'h01FFF2
`define STAT_ADDR       24'hF70018
`define ONBOARD_HI      5'h1E
`define CHAN_HI         11'h7C0

// block attributes
`define ATTR_LOCAL      2'h0
`define ATTR_SHARED_RW  2'h1
`define ATTR_SHARED_RO  2'h2
`define ATTR_SHARED_WP  2'h3

// control register fields and reset values
`define CTRL_DIRECT     0
`define CTRL_IRQ_LSB    1
`define CTRL_IRQ_MSB    3
`define CTRL_WP_LSB     8
`define CTRL_WP_MSB     15
`define CTRL_RESET      16'h0000
`define VEC_RESET       8'h0F

// interrupt and request levels
`define SER_LEVEL_DFLT  3'h6
`define SER_LEVEL_MAX   3'h5
`define BUS_LEVEL_MAX   3'h4

`endif

/* File: src/unused_placeholder_none.v */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* File: testbench/sysbus_bridge_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module sysbus_bridge_sva (
   // clock and straps
   input wire logic        clock_in,
   input wire logic        rst_in,
   input wire logic [2:0]  bus_level_in,
   input wire logic        ser_wired_in,
   input wire logic [2:0]  ser_level_in,
   // processor and backplane
   input wire logic        cpu_ack_out,
   input wire logic        cpu_err_out,
   input wire logic [2:0]  cpu_ipl_out,
   input wire logic        bp_sel_in,
   input wire logic        bp_ack_out,
   input wire logic        bp_err_out,
   input wire logic [4:0]  bus_req_out,
   input wire logic        bus_grant_in,
   input wire logic        bus_busy_out,
   input wire logic        mst_strobe_out,
   input wire logic [23:1] mst_addr_out,
   input wire logic [7:1]  bp_irq_out
);
   // straps clamp as the design does; held still in use
   logic [2:0] lv;
   logic [2:0] sl;
   assign lv = (bus_level_in > 3'h4) ? 3'h4 : bus_level_in;
   assign sl = !ser_wired_in ? 3'h6 :
      (ser_level_in == 3'h0 || ser_level_in > 3'h5) ? 3'h5 : ser_level_in;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   irq_one_line_a: assert property ($onehot0(bp_irq_out))
      else $error("several irq lines");
   req_level_a: assert property (|bus_req_out |->
      bus_req_out == (5'h01 << lv)) else $error("bad request level");
   strobe_granted_a: assert property ($rose(mst_strobe_out) |->
      bus_busy_out && $past(bus_grant_in, 2)) else $error("no grant");
   offboard_only_a: assert property (mst_strobe_out |->
      mst_addr_out[23:17] != 7'h00) else $error("ram on backplane");
   busy_after_req_a: assert property ($rose(bus_busy_out) |->
      $past(bus_req_out) != 5'h00) else $error("master without request");
   ser_level_a: assert property (|cpu_ipl_out |->
      cpu_ipl_out == sl) else $error("bad serial level");
   bp_answer_a: assert property (!(bp_ack_out && bp_err_out))
      else $error("ack with error");
   bp_ack_hold_a: assert property (bp_ack_out && bp_sel_in |=>
      bp_ack_out) else $error("ack dropped early");
   cpu_pulse_a: assert property (cpu_ack_out |=>
      !cpu_ack_out && !cpu_err_out) else $error("ack too long");
   cover property ($rose(mst_strobe_out));
   cover property ($rose(bp_err_out));
   cover property (bp_irq_out[7]);
endmodule // sysbus_bridge_sva
bind sysbus_bridge sysbus_bridge_sva chk (.clock_in(clock_in),
   .rst_in(rst_in), .bus_level_in(bus_level_in),
   .ser_wired_in(ser_wired_in), .ser_level_in(ser_level_in),
   .cpu_ack_out(cpu_ack_out), .cpu_err_out(cpu_err_out),
   .cpu_ipl_out(cpu_ipl_out), .bp_sel_in(bp_sel_in),
   .bp_ack_out(bp_ack_out), .bp_err_out(bp_err_out),
   .bus_req_out(bus_req_out), .bus_grant_in(bus_grant_in),
   .bus_busy_out(bus_busy_out), .mst_strobe_out(mst_strobe_out),
   .mst_addr_out(mst_addr_out), .bp_irq_out(bp_irq_out));
`default_nettype wire

/* File: testbench/sysbus_bridge_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
   $display("FAIL %0t %h %h", $time, (a), (b)); end end
module sysbus_bridge_tb_top;
   logic clock_in, rst_in, attr_wr_in, cpu_req_in, cpu_we_in, cpu_iack_in;
   logic bp_sel_in, bp_we_in, bus_grant_in, mst_ack_in, slow, e, got, sw;
   logic cpu_ack_out, cpu_err_out, ram_en_out, ram_we_out, bp_ack_out;
   logic bp_err_out, bus_busy_out, mst_strobe_out, mst_we_out;
   logic [6:0] attr_idx_in;
   logic [1:0] attr_val_in, ser_irq_in;
   logic [23:1] cpu_addr_in, bp_addr_in, mst_addr_out;
   logic [15:0] cpu_wdata_in, bp_wdata_in, ram_rdata_in, mst_rdata_in, r;
   logic [15:0] cpu_rdata_out, ram_wdata_out, bp_rdata_out, mst_wdata_out;
   logic [16:1] ram_addr_out;
   logic [2:0] cpu_ipl_out;
   logic [4:0] bus_req_out;
   logic [7:1] bp_irq_out;
   logic [15:0] mem [0:65535];
   int n_errors, checks_done;
   localparam logic [23:1] CTRL = 23'h00FFF8;
   sysbus_bridge dut (.clock_in(clock_in), .rst_in(rst_in),
      .win_sel_in(6'h01), .base_kb_in(8'h04), .bus_level_in(3'h2),
      .ser_wired_in(sw), .ser_level_in(3'h3), .attr_wr_in(attr_wr_in),
      .attr_idx_in(attr_idx_in), .attr_val_in(attr_val_in),
      .cpu_req_in(cpu_req_in), .cpu_we_in(cpu_we_in),
      .cpu_iack_in(cpu_iack_in), .cpu_addr_in(cpu_addr_in),
      .cpu_wdata_in(cpu_wdata_in), .cpu_rdata_out(cpu_rdata_out),
      .cpu_ack_out(cpu_ack_out), .cpu_err_out(cpu_err_out),
      .ser_irq_in(ser_irq_in), .cpu_ipl_out(cpu_ipl_out),
      .ram_en_out(ram_en_out), .ram_we_out(ram_we_out),
      .ram_addr_out(ram_addr_out), .ram_wdata_out(ram_wdata_out),
      .ram_rdata_in(ram_rdata_in), .bp_sel_in(bp_sel_in),
      .bp_we_in(bp_we_in), .bp_addr_in(bp_addr_in),
      .bp_wdata_in(bp_wdata_in), .bp_rdata_out(bp_rdata_out),
      .bp_ack_out(bp_ack_out), .bp_err_out(bp_err_out),
      .bus_req_out(bus_req_out), .bus_grant_in(bus_grant_in),
      .bus_busy_out(bus_busy_out), .mst_strobe_out(mst_strobe_out),
      .mst_we_out(mst_we_out), .mst_addr_out(mst_addr_out),
      .mst_wdata_out(mst_wdata_out), .mst_ack_in(mst_ack_in),
      .mst_rdata_in(mst_rdata_in), .bp_irq_out(bp_irq_out));
   sysbus_partner far (.clock_in(clock_in), .rst_in(rst_in),
      .slow_in(slow), .bus_req_in(bus_req_out),
      .bus_grant_out(bus_grant_in), .strobe_in(mst_strobe_out),
      .we_in(mst_we_out), .addr_in(mst_addr_out),
      .wdata_in(mst_wdata_out), .ack_out(mst_ack_in),
      .rdata_out(mst_rdata_in));
   ////////////////////////////////////////////////////////////////////
   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end
   // synchronous ram; idle data lines float
   always @(posedge clock_in) begin
      if (ram_en_out) begin
         if (ram_we_out) mem[ram_addr_out] <= ram_wdata_out;
         ram_rdata_in <= mem[ram_addr_out];
      end else ram_rdata_in <= ~ram_rdata_in;
   end
   function automatic logic [23:1] bpa(input logic [7:0] blk);
      logic [23:0] b;
      b = {6'h01, 8'h04 + blk, 10'h000};
      return b[23:1];
   endfunction
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cpu(input logic w, input logic [23:1] a,
                      input logic [15:0] d);
      int i;
      cpu_req_in <= 1'b1; cpu_we_in <= w; cpu_addr_in <= a;
      cpu_wdata_in <= d;
      got = 1'b0;
      for (i = 0; i < 80 && !got; i++) begin
         @(posedge clock_in);
         got = (cpu_ack_out === 1'b1) || (cpu_err_out === 1'b1);
      end
      r = cpu_rdata_out;
      cpu_req_in <= 1'b0;
      if (!got) begin
         n_errors++;
         $display("FAIL %0t %h %h", $time, a, d);
         end_sim();
      end
      // backplane ack falls through two flops before the port idles
      repeat (4) @(posedge clock_in);
   endtask
   // a missed window answers nothing, so the 40-cycle wait ends without a failure here
   task automatic bp(input logic w, input logic [23:1] a,
                     input logic [15:0] d);
      int i;
      bp_sel_in <= 1'b1; bp_we_in <= w; bp_addr_in <= a; bp_wdata_in <= d;
      got = 1'b0;
      for (i = 0; i < 40 && !got; i++) begin
         @(posedge clock_in);
         got = (bp_ack_out === 1'b1) || (bp_err_out === 1'b1);
      end
      r = bp_rdata_out; e = bp_err_out;
      bp_sel_in <= 1'b0; bp_addr_in <= ~a; bp_wdata_in <= ~d;
      repeat (6) @(posedge clock_in);
   endtask
   task automatic attr(input logic [6:0] b, input logic [1:0] v);
      attr_wr_in <= 1'b1; attr_idx_in <= b; attr_val_in <= v;
      @(posedge clock_in);
      attr_wr_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic t_map;
      bp(1'b0, bpa(8'd2), 16'h0000); `CHK(e, 1'b1)
      attr(7'd2, 2'h1); attr(7'd3, 2'h2); attr(7'd16, 2'h3);
      cpu(1'b1, 23'h000400, 16'h1234); cpu(1'b1, 23'h000600, 16'h3333);
      cpu(1'b1, 23'h002000, 16'h1616);
      bp(1'b0, bpa(8'd2), 16'h0000); `CHK(r, 16'h1234)
      bp(1'b1, bpa(8'd2), 16'h4321); `CHK(mem[16'h0400], 16'h4321)
      bp(1'b1, bpa(8'd3), 16'hBEEF); `CHK(mem[16'h0600], 16'h3333)
      bp(1'b1, bpa(8'd16), 16'hAAAA); `CHK(mem[16'h2000], 16'hAAAA)
      cpu(1'b1, CTRL, 16'h0200);
      cpu(1'b0, CTRL, 16'h0000); `CHK(r, 16'h0200)
      bp(1'b1, bpa(8'd16), 16'h5555); `CHK(mem[16'h2000], 16'hAAAA)
      cpu(1'b1, CTRL, 16'h0000);
      bp(1'b0, 23'h100200, 16'h0000); `CHK(got, 1'b0)
      $display("t_map done");
   endtask
   task automatic t_ind;
      slow <= 1'b1;
      fork
         cpu(1'b0, 23'h080123, 16'h0000);
         begin
            repeat (4) @(posedge clock_in);
            `CHK(bus_req_out, 5'h04)
            `CHK(cpu_ack_out, 1'b0)
         end
      join
      `CHK(r, 16'h5B79)
      repeat (3) @(posedge clock_in);
      `CHK(bus_busy_out, 1'b0)
      `CHK(bus_req_out, 5'h00)
      slow <= 1'b0;
      $display("t_ind done");
   endtask
   task automatic t_dir;
      int i;
      cpu(1'b1, CTRL, 16'h0001);
      for (i = 0; i < 20 && bus_busy_out !== 1'b1; i++) @(posedge clock_in);
      `CHK(bus_busy_out, 1'b1)
      cpu(1'b0, 23'h7B800C, 16'h0000); `CHK(r, 16'h0001)
      cpu(1'b1, 23'h080010, 16'h7777);
      repeat (4) @(posedge clock_in);
      `CHK(bus_busy_out, 1'b1)
      cpu(1'b1, CTRL, 16'h0000);
      repeat (4) @(posedge clock_in);
      `CHK(bus_busy_out, 1'b0)
      $display("t_dir done");
   endtask
   task automatic t_irq;
      int l;
      `CHK(bp_irq_out, 7'h00)
      for (l = 1; l < 8; l++) begin
         cpu(1'b1, CTRL, {12'h000, l[2:0], 1'b0});
         repeat (2) @(posedge clock_in);
         `CHK(bp_irq_out, 7'h01 << (l - 1))
      end
      cpu(1'b1, CTRL, 16'h0000);
      repeat (2) @(posedge clock_in);
      `CHK(bp_irq_out, 7'h00)
      $display("t_irq done");
   endtask
   task automatic t_ser;
      ser_irq_in <= 2'b10;
      repeat (4) @(posedge clock_in);
      `CHK(cpu_ipl_out, 3'h6)
      cpu_iack_in <= 1'b1;
      cpu(1'b0, 23'h000000, 16'h0000); `CHK(r[7:0], 8'h0F)
      cpu_iack_in <= 1'b0;
      cpu(1'b1, 23'h00FFF9, 16'h4242);
      cpu_iack_in <= 1'b1;
      cpu(1'b0, 23'h000000, 16'h0000); `CHK(r[7:0], 8'h42)
      cpu_iack_in <= 1'b0; ser_irq_in <= 2'b00;
      repeat (4) @(posedge clock_in);
      `CHK(cpu_ipl_out, 3'h0)
      sw <= 1'b1; ser_irq_in <= 2'b01;
      repeat (4) @(posedge clock_in);
      `CHK(cpu_ipl_out, 3'h3)
      ser_irq_in <= 2'b00;
      repeat (4) @(posedge clock_in);
      sw <= 1'b0;
      $display("t_ser done");
   endtask
   initial begin
      n_errors = 0; checks_done = 0; rst_in = 1'b1; slow = 1'b0; sw = 1'b0;
      attr_wr_in = 1'b0; attr_idx_in = 7'h00; attr_val_in = 2'h0;
      cpu_req_in = 1'b0; cpu_we_in = 1'b0; cpu_iack_in = 1'b0;
      cpu_addr_in = 23'h000000; cpu_wdata_in = 16'h0000;
      bp_sel_in = 1'b0; bp_we_in = 1'b0; bp_addr_in = 23'h000000;
      bp_wdata_in = 16'h0000; ser_irq_in = 2'b00; ram_rdata_in = 16'h0000;
      repeat (8) @(posedge clock_in);
      rst_in <= 1'b0;
      // straps need the synchronisers filled first
      repeat (4) @(posedge clock_in);
      t_map(); t_ind(); t_dir(); t_irq(); t_ser();
      end_sim();
   end
endmodule // sysbus_bridge_tb_top
`default_nettype wire

/* File: testbench/sysbus_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module sysbus_partner (
   // arbitration
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   input  wire logic        slow_in,
   input  wire logic [4:0]  bus_req_in,
   output logic             bus_grant_out,
   // slave transfer
   input  wire logic        strobe_in,
   input  wire logic        we_in,
   input  wire logic [23:1] addr_in,
   input  wire logic [15:0] wdata_in,
   output logic             ack_out,
   output logic [15:0]      rdata_out
);
   logic [3:0] wait_reg;
   always @(posedge clock_in) begin
      if (rst_in) begin
         bus_grant_out <= 1'b0;
         ack_out       <= 1'b0;
         wait_reg      <= 4'h0;
         rdata_out     <= 16'h0000;
      end else begin
         // grant only while some level asks
         bus_grant_out <= (bus_req_in != 5'h00);
         if (!strobe_in) begin
            ack_out   <= 1'b0;
            wait_reg  <= 4'h0;
            // released lines float, never keep old data
            rdata_out <= ~rdata_out;
         end else if (!ack_out) begin
            wait_reg <= wait_reg + 4'h1;
            if (wait_reg == (slow_in ? 4'h9 : 4'h1)) begin
               ack_out   <= 1'b1;
               rdata_out <= we_in ? ~wdata_in : addr_in[16:1] ^ 16'h5A5A;
            end
         end
      end
   end
endmodule // sysbus_partner
`default_nettype wire
